// File: isab_consts.svh
// Constants of the serial programming front end
`ifndef ISAB_CONSTS_SVH
`define ISAB_CONSTS_SVH
`define ISAB_CH_COLON 8'h3a
`define ISAB_CH_CSUM_ERR 8'h58
`define ISAB_CH_CRC_ERR 8'h5a
`define ISAB_CH_ACK 8'h2e
`define ISAB_CH_DENY 8'h50
`define ISAB_SSB_L0 8'hff
`define ISAB_SSB_L1 8'hfe
`define ISAB_SSB_L2 8'hfc
`define ISAB_SSB_ADDR 14'h3ffd
`define ISAB_CRC_HI_ADDR 14'h3ffe
`define ISAB_CRC_LO_ADDR 14'h3fff
`define ISAB_CRC_INIT 16'hffff
`define ISAB_CRC_POLY 16'h1021
`define ISAB_REC_PROG 8'h00
`define ISAB_REC_EOF 8'h01
`define ISAB_REC_WRITE 8'h03
`define ISAB_REC_SHOW 8'h04
`define ISAB_REC_READ 8'h05
`define ISAB_FN_ERASE 8'h07
`define ISAB_FN_SSB 8'h05
`define ISAB_SUB_0 8'h00
`define ISAB_SUB_1 8'h01
`define ISAB_HDR_BYTES 8'h04
`define ISAB_LAST_BIT 4'h7
`define ISAB_FRAME_BITS 4'ha
`define ISAB_LVL_1 2'h1
`define ISAB_LVL_2 2'h2
`endif

// File: isab_host.sv
// Host programming tool on the serial link
`timescale 1ns/1ns
module isab_host (
    input wire logic clock,
    input wire logic txd,
    output logic rxd
);
    int per = 8;
    int ferr = 0;
    logic [7:0] rq[$];
    initial rxd = 1'b1;
    task automatic send_char(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (per) @(negedge clock);
        end
    endtask : send_char
    task automatic calibrate();
        send_char(8'h55);
        repeat (3 * per) @(negedge clock);
    endtask : calibrate
    // Mid-bit sampling at our own rate catches a wrong device rate
    always begin : rx_loop
        logic [7:0] c;
        @(negedge txd);
        repeat (per / 2) @(negedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (per) @(negedge clock);
            c[i] = txd;
        end
        repeat (per) @(negedge clock);
        if (txd !== 1'b1) ferr++;
        rq.push_back(c);
    end
endmodule : isab_host

// File: isab_pkg.sv
// Types of the serial programming front end
package isab_pkg;
    typedef enum logic [2:0] {R_CAL_IDLE, R_CAL_LOW, R_CAL_SKIP, R_IDLE, R_START, R_DATA, R_STOP} isab_rx_e;
    typedef enum logic [2:0] {EX_INIT, EX_IDLE, EX_NV, EX_CR, EX_CHK} isab_ex_e;
    typedef struct packed {
        logic nv_we;
        logic code_ram_we;
        logic erase;
        logic ssb_we;
        logic [13:0] addr;
        logic [7:0] data;
    } isab_mem_s;
    typedef struct packed {
        isab_rx_e rx;
        logic cal;
        logic [15:0] per;
        logic [15:0] cnt;
        logic [3:0] bits;
        logic [7:0] sh;
        logic rx_vld;
        logic txd;
        logic tbusy;
        logic [15:0] tcnt;
        logic [3:0] tbits;
        logic [9:0] tsh;
        logic rep_v;
        logic [7:0] rep_c;
        logic in_rec;
        logic nib;
        logic [3:0] hi;
        logic [7:0] bidx;
        logic [7:0] sum;
        logic [7:0] reclen;
        logic [15:0] addr;
        logic [7:0] rtype;
        logic [63:0][7:0] pbuf;
        isab_ex_e ex;
        logic [5:0] widx;
        logic [15:0] crc;
        logic [15:0] crc_ref;
        logic [7:0] security_setting_byte;
        logic [7:0] cssb;
        logic erased;
        logic app_en;
        logic err;
        isab_mem_s mem;
    } isab_st_s;
endpackage : isab_pkg

// File: isab_top.sv
// Autobaud serial link, record checker, page writer, image CRC and protection
`timescale 1ns/1ns
`include "isab_consts.svh"
module isab_top #(
    parameter int CW = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic rxd,
    input wire logic [7:0] ssb_nv,
    input wire logic image_good_nv,
    output logic txd,
    output isab_pkg::isab_mem_s mem,
    output logic transfer_error_pin,
    output logic app_enable,
    output logic calibrated
);
    isab_pkg::isab_st_s q;
    isab_pkg::isab_st_s s;

    // Level from the two low bits so bypass bits above do not matter
    function automatic logic [1:0] lvl(input logic [7:0] b);
        if (!b[1]) begin
            lvl = `ISAB_LVL_2;
        end else if (!b[0]) begin
            lvl = `ISAB_LVL_1;
        end else begin
            lvl = 2'h0;
        end
    endfunction : lvl

    function automatic logic [4:0] hexval(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            hexval = {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            hexval = {1'b1, c[3:0] + 4'h9};
        end else begin
            hexval = 5'h00;
        end
    endfunction : hexval

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ `ISAB_CRC_POLY) : {r[14:0], 1'b0};
        end
        crc_step = r;
    endfunction : crc_step

    always_comb begin
        logic [4:0] hv;
        logic [7:0] b;
        logic [7:0] nb;
        logic [13:0] wa;
        hv = hexval(q.sh);
        b = {q.hi, hv[3:0]};
        nb = `ISAB_SSB_L0;
        wa = q.addr[13:0] + {8'h00, q.widx};
        s = q;
        s.rx_vld = 1'b0;
        s.mem.nv_we = 1'b0;
        s.mem.code_ram_we = 1'b0;
        s.mem.erase = 1'b0;
        s.mem.ssb_we = 1'b0;

        // Receiver; calibration edge timing first, framing only afterwards
        s.cnt = q.cnt + 16'h1;
        case (q.rx)
            isab_pkg::R_CAL_IDLE: begin
                s.cnt = 16'h1;
                if (!rxd) begin
                    s.rx = isab_pkg::R_CAL_LOW;
                end
            end
            isab_pkg::R_CAL_LOW: begin
                if (rxd) begin
                    s.per = q.cnt;
                    s.cnt = 16'h1;
                    s.rx = isab_pkg::R_CAL_SKIP;
                end
            end
            isab_pkg::R_CAL_SKIP: begin
                // Rest of the U is swallowed: wait for two quiet bit times
                if (!rxd) begin
                    s.cnt = 16'h1;
                end else if ({1'b0, q.cnt} >= {q.per, 1'b0}) begin
                    s.rx = isab_pkg::R_IDLE;
                    s.cal = 1'b1;
                end
            end
            isab_pkg::R_IDLE: begin
                s.cnt = 16'h1;
                if (!rxd) begin
                    s.rx = isab_pkg::R_START;
                end
            end
            isab_pkg::R_START: begin
                if (q.cnt >= {1'b0, q.per[15:1]}) begin
                    s.cnt = 16'h1;
                    s.bits = 4'h0;
                    s.rx = rxd ? isab_pkg::R_IDLE : isab_pkg::R_DATA;
                end
            end
            isab_pkg::R_DATA: begin
                if (q.cnt >= q.per) begin
                    s.cnt = 16'h1;
                    s.sh = {rxd, q.sh[7:1]};
                    s.bits = q.bits + 4'h1;
                    if (q.bits == `ISAB_LAST_BIT) begin
                        s.rx = isab_pkg::R_STOP;
                    end
                end
            end
            isab_pkg::R_STOP: begin
                if (q.cnt >= q.per) begin
                    s.rx = isab_pkg::R_IDLE;
                    s.rx_vld = rxd;
                end
            end
            default: s.rx = isab_pkg::R_CAL_IDLE;
        endcase

        // Record parser: hex pairs into bytes, running sum to zero
        if (q.rx_vld) begin
            if (q.sh == `ISAB_CH_COLON) begin
                s.in_rec = 1'b1;
                s.bidx = 8'h00;
                s.nib = 1'b0;
                s.sum = 8'h00;
            end else if (q.in_rec && !hv[4]) begin
                s.in_rec = 1'b0;
            end else if (q.in_rec && !q.nib) begin
                s.hi = hv[3:0];
                s.nib = 1'b1;
            end else if (q.in_rec) begin
                s.nib = 1'b0;
                s.sum = q.sum + b;
                s.bidx = q.bidx + 8'h1;
                case (q.bidx)
                    8'h00: s.reclen = b;
                    8'h01: s.addr[15:8] = b;
                    8'h02: s.addr[7:0] = b;
                    8'h03: s.rtype = b;
                    default: s.pbuf[6'(q.bidx - `ISAB_HDR_BYTES)] = b;
                endcase
                if (q.bidx == q.reclen + `ISAB_HDR_BYTES) begin
                    s.in_rec = 1'b0;
                    s.rep_v = 1'b1;
                    s.rep_c = `ISAB_CH_ACK;
                    if (s.sum != 8'h00) begin
                        s.rep_c = `ISAB_CH_CSUM_ERR;
                    end else if (q.ex != isab_pkg::EX_IDLE) begin
                        s.rep_c = `ISAB_CH_DENY;
                    end else begin
                        case (q.rtype)
                            `ISAB_REC_PROG: begin
                                if (lvl(q.security_setting_byte) != 2'h0 && !q.erased) begin
                                    s.rep_c = `ISAB_CH_DENY;
                                end else if (q.reclen != 8'h00) begin
                                    s.rep_v = 1'b0;
                                    s.widx = 6'h00;
                                    s.ex = isab_pkg::EX_NV;
                                end
                            end
                            `ISAB_REC_EOF: begin
                                s.rep_v = 1'b0;
                                s.ex = isab_pkg::EX_CHK;
                            end
                            `ISAB_REC_WRITE: begin
                                if (q.pbuf[0] == `ISAB_FN_ERASE && q.pbuf[1] == `ISAB_SUB_0) begin
                                    s.mem.erase = 1'b1;
                                    s.security_setting_byte = `ISAB_SSB_L0;
                                    s.erased = 1'b1;
                                    s.app_en = 1'b0;
                                    s.crc = `ISAB_CRC_INIT;
                                end else if (q.pbuf[0] == `ISAB_FN_SSB) begin
                                    nb = (q.pbuf[1] == `ISAB_SUB_1) ? `ISAB_SSB_L2 : `ISAB_SSB_L1;
                                    if (lvl(nb) < lvl(q.security_setting_byte)) begin
                                        s.rep_c = `ISAB_CH_DENY;
                                    end else begin
                                        s.security_setting_byte = nb;
                                        s.mem.ssb_we = 1'b1;
                                        s.mem.data = nb;
                                    end
                                end
                            end
                            `ISAB_REC_SHOW: begin
                                if (lvl(q.security_setting_byte) == `ISAB_LVL_2 || lvl(q.cssb) == `ISAB_LVL_2) begin
                                    s.rep_c = `ISAB_CH_DENY;
                                end
                            end
                            `ISAB_REC_READ: begin
                                if (lvl(q.security_setting_byte) == `ISAB_LVL_2) begin
                                    s.rep_c = `ISAB_CH_DENY;
                                end else if (q.pbuf[0] == `ISAB_FN_ERASE) begin
                                    s.rep_c = q.security_setting_byte;
                                end
                            end
                            default: s.rep_c = `ISAB_CH_DENY;
                        endcase
                    end
                end
            end
        end

        // Page writer and image check
        case (q.ex)
            isab_pkg::EX_INIT: begin
                s.security_setting_byte = ssb_nv;
                s.cssb = ssb_nv;
                s.app_en = image_good_nv;
                s.mem.code_ram_we = 1'b1;
                s.mem.addr = `ISAB_SSB_ADDR;
                s.mem.data = ssb_nv;
                s.ex = isab_pkg::EX_IDLE;
            end
            isab_pkg::EX_NV, isab_pkg::EX_CR: begin
                s.mem.nv_we = (q.ex == isab_pkg::EX_NV);
                s.mem.code_ram_we = (q.ex == isab_pkg::EX_CR);
                s.mem.addr = wa;
                s.mem.data = q.pbuf[q.widx];
                s.widx = q.widx + 6'h1;
                if (q.ex == isab_pkg::EX_CR) begin
                    if (wa == 14'h0000) begin
                        s.crc = crc_step(`ISAB_CRC_INIT, q.pbuf[q.widx]);
                    end else if (wa < `ISAB_CRC_HI_ADDR) begin
                        s.crc = crc_step(q.crc, q.pbuf[q.widx]);
                    end else if (wa == `ISAB_CRC_HI_ADDR) begin
                        s.crc_ref[15:8] = q.pbuf[q.widx];
                    end else begin
                        s.crc_ref[7:0] = q.pbuf[q.widx];
                    end
                end
                if ({2'b00, q.widx} == q.reclen - 8'h1) begin
                    s.widx = 6'h00;
                    if (q.ex == isab_pkg::EX_NV) begin
                        s.ex = isab_pkg::EX_CR;
                    end else begin
                        s.ex = isab_pkg::EX_IDLE;
                        s.rep_v = 1'b1;
                        s.rep_c = `ISAB_CH_ACK;
                    end
                end
            end
            isab_pkg::EX_CHK: begin
                s.ex = isab_pkg::EX_IDLE;
                s.rep_v = 1'b1;
                s.err = (q.crc != q.crc_ref);
                s.app_en = (q.crc == q.crc_ref);
                s.rep_c = (q.crc == q.crc_ref) ? `ISAB_CH_ACK : `ISAB_CH_CRC_ERR;
            end
            isab_pkg::EX_IDLE: ;
            default: s.ex = isab_pkg::EX_IDLE;
        endcase

        // Transmitter at the calibrated period
        if (!q.tbusy && q.rep_v && q.cal) begin
            s.rep_v = 1'b0;
            s.tbusy = 1'b1;
            s.tsh = {1'b1, q.rep_c, 1'b0};
            s.tbits = 4'h0;
            s.tcnt = 16'h1;
            s.txd = 1'b0;
        end else if (q.tbusy) begin
            s.tcnt = q.tcnt + 16'h1;
            if (q.tcnt >= q.per) begin
                s.tcnt = 16'h1;
                s.tsh = {1'b1, q.tsh[9:1]};
                s.tbits = q.tbits + 4'h1;
                s.txd = s.tsh[0];
                if (s.tbits == `ISAB_FRAME_BITS) begin
                    s.tbusy = 1'b0;
                    s.txd = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.txd <= 1'b1;
            q.security_setting_byte <= `ISAB_SSB_L0;
            q.cssb <= `ISAB_SSB_L0;
            q.crc <= `ISAB_CRC_INIT;
        end else begin
            q <= s;
        end
    end

    assign txd = q.txd;
    assign mem = q.mem;
    assign transfer_error_pin = q.err;
    assign app_enable = q.app_en;
    assign calibrated = q.cal;
endmodule : isab_top

// File: isab_top_asserts.sv
// Port checks for the serial programming front end
`timescale 1ns/1ns
`include "isab_consts.svh"
module isab_top_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic rxd,
    input wire logic [7:0] ssb_nv,
    input wire logic image_good_nv,
    input wire logic txd,
    input wire isab_pkg::isab_mem_s mem,
    input wire logic transfer_error_pin,
    input wire logic app_enable,
    input wire logic calibrated
);
    logic erased_q;
    logic [21:0] first_q;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // First store write of a page, to match its code RAM copy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            erased_q <= 1'b0;
            first_q <= 22'h000000;
        end else begin
            erased_q <= erased_q | mem.erase;
            if ($rose(mem.nv_we)) begin
                first_q <= {mem.addr, mem.data};
            end
        end
    end
    sequence s_nv_end;
        $fell(mem.nv_we);
    endsequence
    sequence s_cr_start;
        mem.code_ram_we && {mem.addr, mem.data} == first_q;
    endsequence
    property p_page_order;
        s_nv_end |-> s_cr_start;
    endproperty
    property p_reset_copy;
        $fell(rst) |-> ##[1:2] (mem.code_ram_we && mem.addr == `ISAB_SSB_ADDR && mem.data == ssb_nv);
    endproperty
    property p_app_boot;
        $fell(rst) |-> ##[1:2] (app_enable == image_good_nv);
    endproperty
    property p_cal_quiet;
        !calibrated |-> txd && !mem.nv_we && !mem.erase && !mem.ssb_we;
    endproperty
    property p_cal_hold;
        calibrated |=> calibrated;
    endproperty
    property p_one_strobe;
        $onehot0({mem.nv_we, mem.code_ram_we, mem.erase, mem.ssb_we});
    endproperty
    property p_locked;
        (!ssb_nv[0] || !ssb_nv[1]) && !erased_q |-> !mem.nv_we;
    endproperty
    property p_ssb_val;
        mem.ssb_we |-> mem.data inside {`ISAB_SSB_L1, `ISAB_SSB_L2};
    endproperty
    property p_ssb_up;
        mem.ssb_we && !ssb_nv[1] && !erased_q |-> mem.data == `ISAB_SSB_L2;
    endproperty
    property p_crc_reply;
        $rose(transfer_error_pin) |-> ##[0:300] !txd;
    endproperty
    a_page_order: assert property (p_page_order) else $error("page not copied");
    a_reset_copy: assert property (p_reset_copy) else $error("no boot copy");
    a_app_boot: assert property (p_app_boot) else $error("bad app enable");
    a_cal_quiet: assert property (p_cal_quiet) else $error("active before cal");
    a_cal_hold: assert property (p_cal_hold) else $error("cal lost");
    a_one_strobe: assert property (p_one_strobe) else $error("strobes overlap");
    a_locked: assert property (p_locked) else $error("locked write");
    a_ssb_val: assert property (p_ssb_val) else $error("bad level code");
    a_ssb_up: assert property (p_ssb_up) else $error("level lowered");
    a_crc_reply: assert property (p_crc_reply) else $error("no error reply");
endmodule : isab_top_asserts

bind isab_top isab_top_asserts isab_top_asserts_i (.clock(clock), .rst(rst), .rxd(rxd),
    .ssb_nv(ssb_nv), .image_good_nv(image_good_nv), .txd(txd), .mem(mem),
    .transfer_error_pin(transfer_error_pin), .app_enable(app_enable), .calibrated(calibrated));

// File: test_isp_autobaud_and_protection.sv
// Self-checking bench for the serial programming front end
`timescale 1ns/1ns
`include "isab_consts.svh"
module test_isp_autobaud_and_protection;
    logic clock, rst, rxd, image_good_nv, txd, transfer_error_pin, app_enable, calibrated;
    logic [7:0] ssb_nv, swd;
    isab_pkg::isab_mem_s mem;
    int err_count = 0;
    int checked = 0;
    int nvn, crn, ern, swn;
    logic [31:0] rs = 32'h3306c719;
    logic [7:0] pg[$];
    logic [15:0] crc;
    isab_top isab_top_i (.clock(clock), .rst(rst), .rxd(rxd), .ssb_nv(ssb_nv),
        .image_good_nv(image_good_nv), .txd(txd), .mem(mem), .transfer_error_pin(transfer_error_pin),
        .app_enable(app_enable), .calibrated(calibrated));
    isab_host isab_host_i (.clock(clock), .txd(txd), .rxd(rxd));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Strobes counted mid-cycle, clear of the edge that launches them
    always @(negedge clock) begin
        nvn += mem.nv_we;
        crn += mem.code_ram_we;
        ern += mem.erase;
        if (mem.ssb_we) begin
            swn++;
            swd = mem.data;
        end
    end
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction : rnd
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
    endfunction : hx
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = `ISAB_CRC_INIT;
        foreach (q[i]) begin
            c ^= {q[i], 8'h00};
            repeat (8) c = c[15] ? (c << 1) ^ `ISAB_CRC_POLY : c << 1;
        end
        return c;
    endfunction : crc16
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic sess(input logic [7:0] s, input logic g);
        rst = 1'b1;
        ssb_nv = s;
        image_good_nv = g;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        isab_host_i.per = 6 + rnd() % 4;
        isab_host_i.rq.delete();
        chk(calibrated, 1'b0);
        isab_host_i.calibrate();
        chk(calibrated, 1'b1);
        chk(app_enable, g);
    endtask : sess
    task automatic rec(input logic [7:0] b[$], input logic bad, input logic [7:0] exp);
        logic [7:0] s, c;
        int n;
        s = 8'h00;
        foreach (b[i]) s += b[i];
        b.push_back((8'h00 - s) ^ {7'h00, bad});
        nvn = 0;
        crn = 0;
        ern = 0;
        swn = 0;
        isab_host_i.send_char(`ISAB_CH_COLON);
        foreach (b[i]) begin
            isab_host_i.send_char(hx(b[i][7:4]));
            isab_host_i.send_char(hx(b[i][3:0]));
        end
        n = 0;
        while (isab_host_i.rq.size() == 0 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        c = isab_host_i.rq.size() ? isab_host_i.rq.pop_front() : 8'hxx;
        chk(c, exp);
    endtask : rec
    task automatic cmd(input logic [7:0] fn, input logic [7:0] sub, input logic [7:0] exp);
        rec({8'h02, 8'h00, 8'h00, `ISAB_REC_WRITE, fn, sub}, 1'b0, exp);
    endtask : cmd
    task automatic prog(input logic [7:0] exp);
        rec({8'h04, 8'h00, 8'h00, `ISAB_REC_PROG, pg}, 1'b0, exp);
    endtask : prog
    initial begin
        #8000000;
        err_count++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        ssb_nv = `ISAB_SSB_L0;
        image_good_nv = 1'b0;
        sess(`ISAB_SSB_L0, 1'b1);
        rec({8'h01, 8'h00, 8'h00, `ISAB_REC_PROG, 8'h11}, 1'b1, `ISAB_CH_CSUM_ERR);
        chk(nvn[7:0], 8'h00);
        pg = {rnd(), rnd(), rnd(), rnd()};
        // First pass carries a corrupted image CRC, second the true one
        for (int k = 0; k < 2; k++) begin
            crc = crc16({pg, `ISAB_SSB_L0}) ^ {15'h0000, k == 0};
            prog(`ISAB_CH_ACK);
            chk(nvn[7:0], 8'h04);
            chk(crn[7:0], 8'h04);
            rec({8'h03, 8'h3f, 8'hfd, `ISAB_REC_PROG, `ISAB_SSB_L0, crc[15:8], crc[7:0]}, 1'b0, `ISAB_CH_ACK);
            rec({8'h00, 8'h00, 8'h00, `ISAB_REC_EOF}, 1'b0, k ? `ISAB_CH_ACK : `ISAB_CH_CRC_ERR);
            chk(transfer_error_pin, k == 0);
        end
        rec({8'h05, 8'h00, 8'h00, `ISAB_REC_SHOW, 8'h00, 8'h00, 8'h3f, 8'hff, 8'h00}, 1'b0, `ISAB_CH_ACK);
        rec({8'h02, 8'h00, 8'h00, `ISAB_REC_READ, `ISAB_FN_ERASE, `ISAB_SUB_0}, 1'b0, `ISAB_SSB_L0);
        cmd(`ISAB_FN_SSB, `ISAB_SUB_1, `ISAB_CH_ACK);
        chk(swd, `ISAB_SSB_L2);
        sess(`ISAB_SSB_L1, 1'b1);
        prog(`ISAB_CH_DENY);
        chk(nvn[7:0], 8'h00);
        cmd(`ISAB_FN_SSB, `ISAB_SUB_0, `ISAB_CH_ACK);
        chk(swd, `ISAB_SSB_L1);
        cmd(`ISAB_FN_ERASE, `ISAB_SUB_0, `ISAB_CH_ACK);
        chk(ern[7:0], 8'h01);
        prog(`ISAB_CH_ACK);
        chk(nvn[7:0], 8'h04);
        sess(`ISAB_SSB_L2, 1'b0);
        rec({8'h05, 8'h00, 8'h00, `ISAB_REC_SHOW, 8'h00, 8'h00, 8'h3f, 8'hff, 8'h00}, 1'b0, `ISAB_CH_DENY);
        cmd(`ISAB_FN_SSB, `ISAB_SUB_0, `ISAB_CH_DENY);
        chk(swn[7:0], 8'h00);
        cmd(`ISAB_FN_SSB, `ISAB_SUB_1, `ISAB_CH_ACK);
        chk(swd, `ISAB_SSB_L2);
        cmd(`ISAB_FN_ERASE, `ISAB_SUB_0, `ISAB_CH_ACK);
        chk(ern[7:0], 8'h01);
        chk(isab_host_i.ferr[7:0], 8'h00);
        print_verdict();
    end
endmodule : test_isp_autobaud_and_protection
